// ===== hdl/ufcfg_pkg.sv
// package for the uart fifo and flow control configuration block
// assumes a register port of 3-bit offsets with 8-bit data, one clock
package ufcfg_pkg;
	// --------------------------------------------------------------
	// register offsets and reset values
	// --------------------------------------------------------------
	localparam logic [2:0] OFS_FIFO_CONTROL = 3'h2;
	localparam logic [2:0] OFS_LINE_CONTROL = 3'h3;
	localparam logic [7:0] RST_FIFO_CONTROL = 8'h00;
	localparam logic [7:0] RST_ENH_FEATURE  = 8'h00;
	localparam logic [7:0] RST_LINE_CONTROL = 8'h1d;
	localparam logic [7:0] ENH_SELECT_CODE  = 8'hbf;
	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int FC_ENABLE_BIT   = 0;
	localparam int FC_RX_RESET_BIT = 1;
	localparam int FC_TX_RESET_BIT = 2;
	localparam int FC_TX_TRIG_LO   = 4;
	localparam int FC_RX_TRIG_LO   = 6;
	localparam int EF_AUTO_CTS_BIT = 7;
	localparam int EF_AUTO_RTS_BIT = 6;
	localparam int EF_SPECIAL_BIT  = 5;
	localparam int EF_GATE_BIT     = 4;
	localparam int LC_DIVISOR_BIT  = 7;
	localparam int LC_BREAK_BIT    = 6;
	localparam int SF_ENH_BLOCK    = 2;
	// --------------------------------------------------------------
	// depths and trigger counts
	// --------------------------------------------------------------
	localparam logic [6:0] FIFO_DEPTH   = 7'h40;
	localparam logic [6:0] SINGLE_DEPTH = 7'h01;
	localparam logic [6:0] RX_TRIG_0 = 7'h08;
	localparam logic [6:0] RX_TRIG_1 = 7'h10;
	localparam logic [6:0] RX_TRIG_2 = 7'h38;
	localparam logic [6:0] RX_TRIG_3 = 7'h3c;
	localparam logic [6:0] TX_TRIG_0 = 7'h08;
	localparam logic [6:0] TX_TRIG_1 = 7'h10;
	localparam logic [6:0] TX_TRIG_2 = 7'h20;
	localparam logic [6:0] TX_TRIG_3 = 7'h38;
	// software flow selections
	typedef enum logic [1:0] {UFC_SW_NONE, UFC_SW_FIRST, UFC_SW_SECOND, UFC_SW_BOTH} ufc_sw_t;
	// register write request
	typedef struct packed {
		logic       wr;
		logic [2:0] addr;
		logic [7:0] data;
	} ufc_wr_t;
	// decoded configuration outputs
	typedef struct packed {
		logic       auto_cts;
		logic       auto_rts;
		logic       special_detect;
		logic       enh_gate;
		ufc_sw_t    tx_sw;
		ufc_sw_t    rx_sw;
		logic       rx_match_any;
		logic       rx_match_seq;
		logic [6:0] depth;
	} ufc_cfg_t;
endpackage

// ===== hdl/ufcfg_top.sv
// uart fifo control, enhanced feature and line control configuration
// assumes writes and reads arrive as single-cycle strobes on i_ref_clk
//
// Contract
// - fifo control at offset 2 reachable only with divisor select clear; resets zero.
// - receive trigger bits 7:6 select 8, 16, 56 or 60 characters.
// - transmit trigger bits 5:4 select 8, 16, 32 or 56 spaces.
// - bit 2 empties transmit fifo, keeps shift register, then self-clears.
// - bit 1 empties receive fifo, keeps shift register, then self-clears.
// - fifo enable low gives one character, ignores other bits, trigger one.
// - fifo enable high makes both buffers 64 characters deep.
// - transmit trigger field writable and effective only with enhanced gate set.
// - enhanced word at offset 2 when line control is 0xbf and block clear.
// - enhanced bit 7 enables automatic cts transmit throttling.
// - enhanced bit 6 enables automatic rts by receive occupancy.
// - bit 5 stores second pause char match and raises special indication.
// - when flow compares second pause char, match is not stored but still raises special indication.
// - enhanced bit 4 gates transmit trigger writes and enables sleep mode.
// - bits 3:2 select transmit software flow: none, first, second, both.
// - bits 1:0 select receive software flow: none, first, second pair.
// - receive 11 with one transmit pair matches either; with none, sequence.
// - setting 1111 sends both pairs and matches only two-character sequences.
// - line control bit 7 maps low offsets to divisor latches.
// - line control bit 6 holds transmit output low while set.
`timescale 1ns/1ps
`default_nettype none
module ufcfg_top (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_b,
	input  wire logic              i_soft_rst,
	input  wire ufcfg_pkg::ufc_wr_t i_wr,
	input  wire logic              i_rd,
	input  wire logic [2:0]        i_rd_addr,
	input  wire logic              i_sf_block,
	input  wire logic              i_tx_serial,
	input  wire logic [6:0]        i_rx_level,
	input  wire logic [6:0]        i_tx_free,
	input  wire logic [7:0]        i_rx_char,
	input  wire logic              i_rx_char_vld,
	input  wire logic [7:0]        i_second_pause_char,
	output logic [7:0]             o_rd_data,
	output logic                   o_tx_pin,
	output logic                   o_divisor_sel,
	output logic                   o_tx_fifo_clr,
	output logic                   o_rx_fifo_clr,
	output logic                   o_rx_thresh,
	output logic                   o_tx_thresh,
	output logic                   o_sleep_en,
	output logic                   o_special_hit,
	output logic                   o_store_char,
	output ufcfg_pkg::ufc_cfg_t    o_cfg
);
	import ufcfg_pkg::*;

	logic [7:0] fifo_control_reg;
	logic [7:0] enh_feature_reg;
	logic [7:0] line_control_reg;
	logic       enh_sel;
	logic       fc_sel;
	logic       wr_fc;
	logic       wr_ef;
	logic [6:0] rx_trig;
	logic [6:0] tx_trig;
	logic       flow_cmp2;
	logic       match2;

	// --------------------------------------------------------------
	// address decode
	// --------------------------------------------------------------
	// enhanced word shadows fifo control under the select code
	assign enh_sel = (line_control_reg == ENH_SELECT_CODE) && !i_sf_block;
	assign fc_sel  = !line_control_reg[LC_DIVISOR_BIT];
	assign wr_fc   = i_wr.wr && i_wr.addr == OFS_FIFO_CONTROL && fc_sel && !enh_sel;
	assign wr_ef   = i_wr.wr && i_wr.addr == OFS_FIFO_CONTROL && enh_sel;

	// --------------------------------------------------------------
	// fifo control register
	// --------------------------------------------------------------
	// resets bits self-clear; trigger fields written only with fifo enabled
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b || i_soft_rst) begin
			fifo_control_reg <= RST_FIFO_CONTROL;
		end else begin
			fifo_control_reg[FC_TX_RESET_BIT] <= 1'b0;
			fifo_control_reg[FC_RX_RESET_BIT] <= 1'b0;
			if (wr_fc) begin
				fifo_control_reg[FC_ENABLE_BIT] <= i_wr.data[FC_ENABLE_BIT];
				if (i_wr.data[FC_ENABLE_BIT]) begin
					fifo_control_reg[FC_RX_TRIG_LO+:2] <= i_wr.data[FC_RX_TRIG_LO+:2];
					if (enh_feature_reg[EF_GATE_BIT]) begin
						fifo_control_reg[FC_TX_TRIG_LO+:2] <= i_wr.data[FC_TX_TRIG_LO+:2];
					end
				end
			end
		end
	end

	// clear pulses to the fifos; shift registers untouched
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_tx_fifo_clr <= 1'b0;
			o_rx_fifo_clr <= 1'b0;
		end else begin
			o_tx_fifo_clr <= wr_fc && i_wr.data[FC_ENABLE_BIT] && i_wr.data[FC_TX_RESET_BIT];
			o_rx_fifo_clr <= wr_fc && i_wr.data[FC_ENABLE_BIT] && i_wr.data[FC_RX_RESET_BIT];
		end
	end

	// --------------------------------------------------------------
	// enhanced feature and line control registers
	// --------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b || i_soft_rst) begin
			enh_feature_reg <= RST_ENH_FEATURE;
		end else if (wr_ef) begin
			enh_feature_reg <= i_wr.data;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b || i_soft_rst) begin
			line_control_reg <= RST_LINE_CONTROL;
		end else if (i_wr.wr && i_wr.addr == OFS_LINE_CONTROL) begin
			line_control_reg <= i_wr.data;
		end
	end

	// --------------------------------------------------------------
	// read path
	// --------------------------------------------------------------
	// trigger and reset bits are write-only and read as zero
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_rd_data <= 8'h00;
		end else if (i_rd && i_rd_addr == OFS_FIFO_CONTROL && enh_sel) begin
			o_rd_data <= enh_feature_reg;
		end else if (i_rd && i_rd_addr == OFS_LINE_CONTROL) begin
			o_rd_data <= line_control_reg;
		end else begin
			o_rd_data <= 8'h00;
		end
	end

	// --------------------------------------------------------------
	// thresholds
	// --------------------------------------------------------------
	always_comb begin
		case (fifo_control_reg[FC_RX_TRIG_LO+:2])
			2'h0: rx_trig = RX_TRIG_0;
			2'h1: rx_trig = RX_TRIG_1;
			2'h2: rx_trig = RX_TRIG_2;
			default: rx_trig = RX_TRIG_3;
		endcase
		case (fifo_control_reg[FC_TX_TRIG_LO+:2])
			2'h0: tx_trig = TX_TRIG_0;
			2'h1: tx_trig = TX_TRIG_1;
			2'h2: tx_trig = TX_TRIG_2;
			default: tx_trig = TX_TRIG_3;
		endcase
		if (!fifo_control_reg[FC_ENABLE_BIT]) begin
			rx_trig = SINGLE_DEPTH;
			tx_trig = SINGLE_DEPTH;
		end else if (!enh_feature_reg[EF_GATE_BIT]) begin
			tx_trig = TX_TRIG_0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_rx_thresh <= 1'b0;
			o_tx_thresh <= 1'b0;
		end else begin
			o_rx_thresh <= i_rx_level >= rx_trig;
			o_tx_thresh <= i_tx_free >= tx_trig;
		end
	end

	// --------------------------------------------------------------
	// line break and divisor select
	// --------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_tx_pin      <= 1'b1;
			o_divisor_sel <= 1'b0;
		end else begin
			o_tx_pin      <= i_tx_serial && !line_control_reg[LC_BREAK_BIT];
			o_divisor_sel <= line_control_reg[LC_DIVISOR_BIT];
		end
	end

	// --------------------------------------------------------------
	// special character detection
	// --------------------------------------------------------------
	// receive flow compares the second pair when bit 0 of the rx field is set
	assign flow_cmp2 = enh_feature_reg[0];
	assign match2    = i_rx_char_vld && i_rx_char == i_second_pause_char;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_special_hit <= 1'b0;
			o_store_char  <= 1'b0;
		end else begin
			o_special_hit <= match2 && enh_feature_reg[EF_SPECIAL_BIT];
			o_store_char  <= i_rx_char_vld && !(match2 && flow_cmp2);
		end
	end

	// --------------------------------------------------------------
	// decoded configuration
	// --------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_cfg      <= '0;
			o_sleep_en <= 1'b0;
		end else begin
			o_cfg.auto_cts       <= enh_feature_reg[EF_AUTO_CTS_BIT];
			o_cfg.auto_rts       <= enh_feature_reg[EF_AUTO_RTS_BIT];
			o_cfg.special_detect <= enh_feature_reg[EF_SPECIAL_BIT];
			o_cfg.enh_gate       <= enh_feature_reg[EF_GATE_BIT];
			o_cfg.tx_sw          <= ufc_sw_t'({enh_feature_reg[2], enh_feature_reg[3]});
			o_cfg.rx_sw          <= ufc_sw_t'({enh_feature_reg[0], enh_feature_reg[1]});
			o_cfg.rx_match_any   <= enh_feature_reg[1:0] == 2'h3
				&& enh_feature_reg[3] != enh_feature_reg[2];
			o_cfg.rx_match_seq   <= enh_feature_reg[1:0] == 2'h3
				&& enh_feature_reg[3] == enh_feature_reg[2];
			o_cfg.depth          <= fifo_control_reg[FC_ENABLE_BIT] ? FIFO_DEPTH
				: SINGLE_DEPTH;
			o_sleep_en           <= enh_feature_reg[EF_GATE_BIT];
		end
	end

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	property p_fc_selfclear;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		wr_fc ##1 1'b1 |-> !fifo_control_reg[FC_TX_RESET_BIT] && !fifo_control_reg[FC_RX_RESET_BIT];
	endproperty
	a_fc_selfclear: assert property (p_fc_selfclear) else $error("reset bits stuck");

	property p_tx_clr;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		wr_fc && i_wr.data[0] && i_wr.data[2] |=> o_tx_fifo_clr
			##1 (!o_tx_fifo_clr || $past(wr_fc && i_wr.data[0] && i_wr.data[2]));
	endproperty
	a_tx_clr: assert property (p_tx_clr) else $error("tx clear pulse wrong");

	property p_rx_clr;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		wr_fc && i_wr.data[0] && i_wr.data[1] |=> o_rx_fifo_clr;
	endproperty
	a_rx_clr: assert property (p_rx_clr) else $error("rx clear missing");

	property p_single;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		i_rst_b && !fifo_control_reg[0] |=> o_cfg.depth == SINGLE_DEPTH;
	endproperty
	a_single: assert property (p_single) else $error("depth not one");

	property p_deep;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		fifo_control_reg[0] |=> o_cfg.depth == FIFO_DEPTH;
	endproperty
	a_deep: assert property (p_deep) else $error("depth not 64");

	property p_tx_gate;
		@(posedge i_ref_clk) disable iff (!i_rst_b || i_soft_rst)
		wr_fc && !enh_feature_reg[4] |=> $stable(fifo_control_reg[5:4]);
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("tx trigger written ungated");

	property p_break;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		line_control_reg[6] |=> !o_tx_pin;
	endproperty
	a_break: assert property (p_break) else $error("break not low");

	property p_rx_thr;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		fifo_control_reg[7:6] == 2'h2 && fifo_control_reg[0] && i_rx_level == 7'h37 |=> !o_rx_thresh;
	endproperty
	a_rx_thr: assert property (p_rx_thr) else $error("rx threshold early");

	property p_flow2;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		match2 && flow_cmp2 |=> !o_store_char;
	endproperty
	a_flow2: assert property (p_flow2) else $error("flow char stored");

	property p_tx_clr_cause;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_tx_fifo_clr |-> $past(wr_fc && i_wr.data[FC_ENABLE_BIT] && i_wr.data[FC_TX_RESET_BIT]);
	endproperty
	a_tx_clr_cause: assert property (p_tx_clr_cause) else $error("tx clear unasked");

	property p_rx_clr_cause;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_rx_fifo_clr |-> $past(wr_fc && i_wr.data[FC_ENABLE_BIT] && i_wr.data[FC_RX_RESET_BIT]);
	endproperty
	a_rx_clr_cause: assert property (p_rx_clr_cause) else $error("rx clear unasked");

	property p_fc_locked;
		@(posedge i_ref_clk) disable iff (!i_rst_b || i_soft_rst)
		i_wr.wr && i_wr.addr == OFS_FIFO_CONTROL && line_control_reg[LC_DIVISOR_BIT]
			|=> $stable(fifo_control_reg) && !o_tx_fifo_clr && !o_rx_fifo_clr;
	endproperty
	a_fc_locked: assert property (p_fc_locked) else $error("fifo control written");

	property p_efr_hidden;
		@(posedge i_ref_clk) disable iff (!i_rst_b || i_soft_rst)
		i_wr.wr && i_wr.addr == OFS_FIFO_CONTROL && (line_control_reg != ENH_SELECT_CODE || i_sf_block)
			|=> $stable(enh_feature_reg);
	endproperty
	a_efr_hidden: assert property (p_efr_hidden) else $error("enhanced word written");

	property p_disabled_keep;
		@(posedge i_ref_clk) disable iff (!i_rst_b || i_soft_rst)
		wr_fc && !i_wr.data[FC_ENABLE_BIT] |=> $stable(fifo_control_reg[7:4]);
	endproperty
	a_disabled_keep: assert property (p_disabled_keep) else $error("trigger changed");

	property p_break_release;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		i_rst_b && !line_control_reg[LC_BREAK_BIT] |=> o_tx_pin == $past(i_tx_serial);
	endproperty
	a_break_release: assert property (p_break_release) else $error("tx pin held");

	property p_hw_flow;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		i_rst_b |=> o_cfg.auto_cts == $past(enh_feature_reg[EF_AUTO_CTS_BIT])
			&& o_cfg.auto_rts == $past(enh_feature_reg[EF_AUTO_RTS_BIT]);
	endproperty
	a_hw_flow: assert property (p_hw_flow) else $error("flow enables wrong");

	property p_tx_thr;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		fifo_control_reg[0] && enh_feature_reg[EF_GATE_BIT] && fifo_control_reg[5:4] == 2'h3
			&& i_tx_free == 7'h37 |=> !o_tx_thresh;
	endproperty
	a_tx_thr: assert property (p_tx_thr) else $error("tx threshold early");

	property p_special;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		i_rst_b && match2 && enh_feature_reg[EF_SPECIAL_BIT] |=> o_special_hit;
	endproperty
	a_special: assert property (p_special) else $error("special hit missing");

	property p_store;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		i_rst_b && match2 && !flow_cmp2 |=> o_store_char;
	endproperty
	a_store: assert property (p_store) else $error("special char dropped");
endmodule
`default_nettype wire

// ===== verification/ufcfg_remote_dev.sv
// remote serial device model: hands received characters to the block
// assumes the bench clock and calls of send_char from the bench
`timescale 1ns/1ps
`default_nettype none
module ufcfg_remote_dev (
	input  wire logic       i_ref_clk,
	output var  logic [7:0] o_rx_char,
	output var  logic       o_rx_char_vld
);
	logic [7:0] last_char;
	// ----------------------------------------------------------------
	// line idle at start
	// ----------------------------------------------------------------
	initial begin
		o_rx_char = 8'h00;
		o_rx_char_vld = 1'b0;
		last_char = 8'h00;
	end
	// one character for one cycle, then the data lines show its inverse
	task automatic send_char(input logic [7:0] ch);
		@(posedge i_ref_clk);
		o_rx_char <= ch;
		o_rx_char_vld <= 1'b1;
		last_char = ch;
		@(posedge i_ref_clk);
		o_rx_char <= ~last_char; // stale data never looks valid
		o_rx_char_vld <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== verification/uart_fifo_flow_control_config_tb_top.sv
// testbench for the fifo control and flow control configuration block
// assumes a 125 MHz clock and the remote device model beside the block
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_flow_control_config_tb_top;
	import ufcfg_pkg::*;
	logic i_ref_clk, i_rst_b, i_soft_rst, i_rd, i_sf_block, i_tx_serial;
	ufc_wr_t    i_wr;
	logic [2:0] i_rd_addr;
	logic [6:0] i_rx_level, i_tx_free;
	logic [7:0] rx_char, o_rd_data, rd_val, pause2;
	logic       rx_vld, o_tx_pin, o_divisor_sel, o_tx_fifo_clr, o_rx_fifo_clr;
	logic       o_rx_thresh, o_tx_thresh, o_sleep_en, o_special_hit, o_store_char;
	ufc_cfg_t   o_cfg, exp_cfg;
	int         miscompares = 0;
	int         checks_done = 0;
	logic [6:0] rxt [4] = '{RX_TRIG_0, RX_TRIG_1, RX_TRIG_2, RX_TRIG_3};
	logic [6:0] txt [4] = '{TX_TRIG_0, TX_TRIG_1, TX_TRIG_2, TX_TRIG_3};
	// ----------------------------------------------------------------
	// block, far side model, clock
	// ----------------------------------------------------------------
	ufcfg_top i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_soft_rst(i_soft_rst),
		.i_wr(i_wr), .i_rd(i_rd), .i_rd_addr(i_rd_addr), .i_sf_block(i_sf_block),
		.i_tx_serial(i_tx_serial), .i_rx_level(i_rx_level), .i_tx_free(i_tx_free),
		.i_rx_char(rx_char), .i_rx_char_vld(rx_vld), .i_second_pause_char(pause2),
		.o_rd_data(o_rd_data), .o_tx_pin(o_tx_pin), .o_divisor_sel(o_divisor_sel),
		.o_tx_fifo_clr(o_tx_fifo_clr), .o_rx_fifo_clr(o_rx_fifo_clr),
		.o_rx_thresh(o_rx_thresh), .o_tx_thresh(o_tx_thresh), .o_sleep_en(o_sleep_en),
		.o_special_hit(o_special_hit), .o_store_char(o_store_char), .o_cfg(o_cfg));
	ufcfg_remote_dev u_dev (.i_ref_clk(i_ref_clk), .o_rx_char(rx_char), .o_rx_char_vld(rx_vld));
	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// software flow code to selection, first pair on the high bit
	function automatic ufc_sw_t sw_sel(input logic [1:0] f);
		case (f)
			2'b10: return UFC_SW_FIRST;
			2'b01: return UFC_SW_SECOND;
			2'b11: return UFC_SW_BOTH;
			default: return UFC_SW_NONE;
		endcase
	endfunction
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_ref_clk) i_wr <= {1'b1, a, d};
		@(posedge i_ref_clk) i_wr <= '0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge i_ref_clk) begin
			i_rd <= 1'b1;
			i_rd_addr <= a;
		end
		@(posedge i_ref_clk) i_rd <= 1'b0;
		#1 rd_val = o_rd_data;
	endtask
	task automatic settle();
		repeat (2) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic set_efr(input logic [7:0] v);
		wr(OFS_LINE_CONTROL, ENH_SELECT_CODE);
		wr(OFS_FIFO_CONTROL, v);
		wr(OFS_LINE_CONTROL, 8'h00);
		settle();
	endtask
	task automatic lvl(input logic [6:0] rl, tf, input logic er, et);
		@(posedge i_ref_clk) begin
			i_rx_level <= rl;
			i_tx_free <= tf;
		end
		settle();
		chk({o_rx_thresh, o_tx_thresh}, {er, et});
	endtask
	task automatic special_try(input logic [7:0] ch, input logic eh, es);
		logic hit, st;
		hit = 0;
		st = 0;
		fork
			u_dev.send_char(ch);
			repeat (4) begin
				@(posedge i_ref_clk);
				#1;
				hit = hit | o_special_hit;
				st = st | o_store_char;
			end
		join
		chk({hit, st}, {eh, es});
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd(OFS_LINE_CONTROL);
		chk(rd_val, RST_LINE_CONTROL);
		rd(OFS_FIFO_CONTROL);
		chk(rd_val, 8'h00);
		rd(3'h5);
		chk(rd_val, 8'h00);
		chk({o_cfg >> 7, o_divisor_sel, o_tx_pin}, 2'b01);
	endtask
	task automatic t_fifo();
		wr(OFS_FIFO_CONTROL, 8'h07);
		chk({o_tx_fifo_clr, o_rx_fifo_clr}, 2'b11);
		@(posedge i_ref_clk);
		#1;
		chk({o_tx_fifo_clr, o_rx_fifo_clr, o_cfg.depth}, {2'b00, FIFO_DEPTH});
		wr(OFS_FIFO_CONTROL, 8'h03);
		chk({o_tx_fifo_clr, o_rx_fifo_clr}, 2'b01);
		wr(OFS_FIFO_CONTROL, 8'h05);
		chk({o_tx_fifo_clr, o_rx_fifo_clr}, 2'b10);
		for (int k = 0; k < 4; k++) begin
			wr(OFS_FIFO_CONTROL, {k[1:0], 2'b11, 4'h1});
			lvl(rxt[k] - 7'h01, TX_TRIG_0 - 7'h01, 1'b0, 1'b0);
			lvl(rxt[k], TX_TRIG_0, 1'b1, 1'b1);
		end
		set_efr(8'h10);
		for (int k = 0; k < 4; k++) begin
			wr(OFS_FIFO_CONTROL, {2'b00, k[1:0], 4'h1});
			lvl(7'h00, txt[k] - 7'h01, 1'b0, 1'b0);
			lvl(7'h00, txt[k], 1'b0, 1'b1);
		end
	endtask
	task automatic t_efr();
		logic [7:0] v;
		for (int i = 0; i < 16; i++) begin
			v = {(i[0] ? 4'hf : 4'h0), i[3:0]};
			set_efr(v);
			exp_cfg = '{v[7], v[6], v[5], v[4], sw_sel(v[3:2]), sw_sel(v[1:0]),
				v[3:0] == 4'hb || v[3:0] == 4'h7,
				v[3:0] == 4'h3 || v[3:0] == 4'hf, FIFO_DEPTH};
			chk(o_cfg, exp_cfg);
			chk(o_sleep_en, v[4]);
		end
		wr(OFS_LINE_CONTROL, ENH_SELECT_CODE);
		rd(OFS_FIFO_CONTROL);
		chk(rd_val, 8'hff);
		wr(OFS_LINE_CONTROL, 8'h00);
		i_sf_block <= 1'b1;
		set_efr(8'h00);
		chk(o_cfg, exp_cfg);
		i_sf_block <= 1'b0;
	endtask
	task automatic t_special();
		set_efr(8'h20);
		special_try(8'h5a, 1'b1, 1'b1);
		special_try(8'h33, 1'b0, 1'b1);
		pause2 <= 8'h33;
		special_try(8'h33, 1'b1, 1'b1);
		pause2 <= 8'h5a;
		set_efr(8'h21);
		special_try(8'h5a, 1'b1, 1'b0);
		set_efr(8'h00);
		special_try(8'h5a, 1'b0, 1'b1);
	endtask
	task automatic t_line();
		wr(OFS_FIFO_CONTROL, 8'hc6);
		chk({o_tx_fifo_clr, o_rx_fifo_clr}, 2'b00);
		settle();
		chk(o_cfg.depth, SINGLE_DEPTH);
		lvl(7'h00, 7'h00, 1'b0, 1'b0);
		lvl(7'h01, 7'h01, 1'b1, 1'b1);
		wr(OFS_LINE_CONTROL, 8'h40);
		settle();
		chk(o_tx_pin, 1'b0);
		wr(OFS_LINE_CONTROL, 8'h80);
		wr(OFS_FIFO_CONTROL, 8'h07);
		chk({o_tx_fifo_clr, o_rx_fifo_clr}, 2'b00);
		settle();
		chk({o_divisor_sel, o_tx_pin, o_cfg.depth}, {2'b11, SINGLE_DEPTH});
		@(posedge i_ref_clk) i_soft_rst <= 1'b1;
		@(posedge i_ref_clk) i_soft_rst <= 1'b0;
		rd(OFS_LINE_CONTROL);
		chk(rd_val, RST_LINE_CONTROL);
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		i_rst_b = 1'b0;
		i_soft_rst = 1'b0;
		i_wr = '0;
		i_rd = 1'b0;
		i_rd_addr = 3'h0;
		i_sf_block = 1'b0;
		i_tx_serial = 1'b1;
		pause2 = 8'h5a;
		i_rx_level = 7'h00;
		i_tx_free = 7'h00;
		repeat (2) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		t_reset();
		t_fifo();
		t_efr();
		t_special();
		t_line();
		complete_run();
	end
	initial begin
		#200000;
		miscompares++;
		complete_run();
	end
endmodule
`default_nettype wire
